// [verilog/twst_slave_tx.sv]
// Two-wire slave transmitter with status codes and bus error recovery
`timescale 1ns/1ps

// What this block does
// - Own address read acked reports A8
// - Lost arbitration then addressed reports B0
// - Byte sent, ACK received reports B8
// - Byte sent, NACK received reports C0
// - Last byte yet ACK reports C8
// - Recognition follows ack enable and general call
// - Start request with the flag clear that leaves transmit issues START when bus free
// - Misplaced START or STOP reports 00
// - Bus error sets the interrupt flag
// - Stop plus flag clear recovers, clears stop
// - Recovery releases lines, sends no STOP
// - Repeated START begins new address phase
// - Status low prescaler bits read zero
// - Read bit enters transmit, else receive
// - Not addressed after last byte, sends ones
module twst_slave_tx (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire twst_pkg::twst_sw_t sw,
  input  wire logic [6:0]        own_addr,
  input  wire logic              arb_lost,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  output logic                   sda_o,
  output logic                   sda_oe,
  output twst_pkg::twst_stat_t   stat
);

  logic [2:0]            scl_sync_q;
  logic [2:0]            sda_sync_q;
  twst_pkg::twst_state_t state_q;
  logic [3:0]            cnt_q;
  logic [7:0]            shift_q;
  logic [7:0]            tx_q;
  logic [7:0]            data_q;
  logic [7:0]            code_q;
  logic [7:0]            status_q;
  logic                  raise_q;
  logic                  flag_q;
  logic                  stop_q;
  logic                  last_q;
  logic                  ack_q;
  logic                  arb_q;
  logic                  rx_q;
  logic                  busy_q;
  logic                  pend_q;
  logic                  issue_q;
  logic                  sda_oe_q;
  logic                  scl_oe_q;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_c;
  logic                  stop_c;
  logic                  flag_ack;
  logic                  in_frame;
  logic                  recover;
  logic                  leave_tx;

  function automatic logic is_tx_code(input logic [7:0] c);
    is_tx_code = (c == twst_pkg::ST_OWN_READ) || (c == twst_pkg::ST_ARB_READ)
              || (c == twst_pkg::ST_DATA_ACK);
  endfunction

  function automatic logic addr_hit(input logic [7:0] a, input logic [6:0] own,
                                    input logic ae, input logic gce);
    addr_hit = ae && ((a[7:1] == own)
            || (gce && !a[0] && (a[7:1] == twst_pkg::GC_ADDR)));
  endfunction

  // Pin synchronisers plus edge stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
    end
  end

  assign scl_rise = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall = !scl_sync_q[1] && scl_sync_q[2];
  assign start_c  = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[1] && sda_sync_q[2];
  assign stop_c   = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[1] && !sda_sync_q[2];
  assign flag_ack = sw.flag_clear && flag_q;
  assign in_frame = (state_q == twst_pkg::S_ADDR && cnt_q != 4'h0)
                 || state_q == twst_pkg::S_ADDR_ACK || state_q == twst_pkg::S_TX_BIT
                 || state_q == twst_pkg::S_TX_ACK;
  assign recover  = state_q == twst_pkg::S_ERR && flag_ack && stop_q;
  assign leave_tx = state_q == twst_pkg::S_WAIT && flag_ack && !is_tx_code(code_q);

  // Data byte written by software
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_q <= twst_pkg::DATA_RESET;
    end else if (sw.data_load) begin
      data_q <= sw.data;
    end
  end

  // Arbitration loss remembered until address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      arb_q <= 1'b0;
    end else if (arb_lost) begin
      arb_q <= 1'b1;
    end else if (state_q == twst_pkg::S_ADDR_ACK && scl_fall) begin
      arb_q <= 1'b0;
    end
  end

  // Main transfer sequencer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q  <= twst_pkg::S_IDLE;
      cnt_q    <= 4'h0;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      code_q   <= twst_pkg::ST_NO_INFO;
      raise_q  <= 1'b0;
      last_q   <= 1'b0;
      ack_q    <= 1'b0;
      rx_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      raise_q <= 1'b0;
      if ((start_c || stop_c) && in_frame) begin
        state_q  <= twst_pkg::S_ERR;
        code_q   <= twst_pkg::ST_BUS_ERR;
        raise_q  <= 1'b1;
        sda_oe_q <= 1'b0;
      end else if (start_c && state_q != twst_pkg::S_WAIT && state_q != twst_pkg::S_ERR) begin
        state_q  <= twst_pkg::S_ADDR;
        cnt_q    <= 4'h0;
        rx_q     <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_c && state_q != twst_pkg::S_WAIT && state_q != twst_pkg::S_ERR) begin
        state_q  <= twst_pkg::S_IDLE;
        rx_q     <= 1'b0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          twst_pkg::S_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          twst_pkg::S_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_sync_q[1]};
              cnt_q   <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == twst_pkg::ADDR_BITS) begin
              cnt_q <= 4'h0;
              if (addr_hit(shift_q, own_addr, sw.ack_enable, sw.general_call_enable)) begin
                sda_oe_q <= 1'b1;
                state_q  <= twst_pkg::S_ADDR_ACK;
              end else begin
                state_q <= twst_pkg::S_IDLE;
              end
            end
          end
          twst_pkg::S_ADDR_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              if (shift_q[0]) begin
                state_q <= twst_pkg::S_WAIT;
                raise_q <= 1'b1;
                code_q  <= arb_q ? twst_pkg::ST_ARB_READ : twst_pkg::ST_OWN_READ;
              end else begin
                rx_q    <= 1'b1;
                state_q <= twst_pkg::S_IDLE;
              end
            end
          end
          twst_pkg::S_WAIT: begin
            if (flag_ack) begin
              if (is_tx_code(code_q)) begin
                // last byte when ack enable low
                tx_q     <= {data_q[6:0], 1'b1};
                last_q   <= !sw.ack_enable;
                cnt_q    <= 4'h0;
                sda_oe_q <= !data_q[7];
                state_q  <= twst_pkg::S_TX_BIT;
              end else begin
                // NACK or last-byte path leaves, no data needed
                state_q  <= twst_pkg::S_IDLE;
                sda_oe_q <= 1'b0;
              end
            end
          end
          twst_pkg::S_TX_BIT: begin
            if (scl_fall) begin
              if (cnt_q == twst_pkg::LAST_TX_BIT) begin
                sda_oe_q <= 1'b0;
                state_q  <= twst_pkg::S_TX_ACK;
              end else begin
                cnt_q    <= cnt_q + 4'h1;
                sda_oe_q <= !tx_q[7];
                tx_q     <= {tx_q[6:0], 1'b1};
              end
            end
          end
          twst_pkg::S_TX_ACK: begin
            if (scl_rise) begin
              ack_q <= !sda_sync_q[1];
            end else if (scl_fall) begin
              state_q <= twst_pkg::S_WAIT;
              raise_q <= 1'b1;
              code_q  <= !ack_q ? twst_pkg::ST_DATA_NACK
                       : (last_q ? twst_pkg::ST_LAST_ACK : twst_pkg::ST_DATA_ACK);
            end
          end
          twst_pkg::S_ERR: begin
            sda_oe_q <= 1'b0;
            if (recover) begin
              state_q <= twst_pkg::S_IDLE;
            end
          end
          default: begin
            state_q  <= twst_pkg::S_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Interrupt flag and status, set wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_q   <= 1'b0;
      status_q <= twst_pkg::ST_NO_INFO;
    end else if (raise_q) begin
      flag_q   <= 1'b1;
      status_q <= code_q & twst_pkg::STATUS_MASK;
    end else if (flag_ack) begin
      flag_q   <= 1'b0;
      status_q <= twst_pkg::ST_NO_INFO;
    end
  end

  // Stop bit, software sets, recovery clears
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stop_q <= 1'b0;
    end else if (sw.stop_set) begin
      stop_q <= 1'b1;
    end else if (recover) begin
      stop_q <= 1'b0;
    end
  end

  // Bus busy between START and STOP
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else if (start_c) begin
      busy_q <= 1'b1;
    end else if (stop_c) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_q  <= 1'b0;
      issue_q <= 1'b0;
    end else begin
      issue_q <= pend_q && !busy_q && !leave_tx;
      if (leave_tx && sw.start_request) begin
        pend_q <= 1'b1;
      end else if (pend_q && !busy_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= state_q == twst_pkg::S_WAIT && !flag_ack;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign stat   = '{status_register:  status_q,
                    interrupt_flag:   flag_q,
                    stop_request_bit: stop_q,
                    start_issue:      issue_q,
                    slave_rx:         rx_q};

endmodule

// [verilog/twst_pkg.sv]
// Constants and carrier types for the two-wire slave transmitter
package twst_pkg;

  localparam logic [7:0] ST_OWN_READ  = 8'hA8;
  localparam logic [7:0] ST_ARB_READ  = 8'hB0;
  localparam logic [7:0] ST_DATA_ACK  = 8'hB8;
  localparam logic [7:0] ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK  = 8'hC8;
  localparam logic [7:0] ST_NO_INFO   = 8'hF8;
  localparam logic [7:0] ST_BUS_ERR   = 8'h00;
  localparam logic [7:0] STATUS_MASK  = 8'hF8;

  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [3:0] ADDR_BITS    = 4'h8;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;
  localparam logic [7:0] DATA_RESET   = 8'hFF;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_ADDR     = 3'b001,
    S_ADDR_ACK = 3'b010,
    S_TX_BIT   = 3'b011,
    S_TX_ACK   = 3'b100,
    S_WAIT     = 3'b101,
    S_ERR      = 3'b110
  } twst_state_t;

  typedef struct packed {
    logic       ack_enable;
    logic       general_call_enable;
    logic       start_request;
    logic       stop_set;
    logic       flag_clear;
    logic       data_load;
    logic [7:0] data;
  } twst_sw_t;

  typedef struct packed {
    logic [7:0] status_register;
    logic       interrupt_flag;
    logic       stop_request_bit;
    logic       start_issue;
    logic       slave_rx;
  } twst_stat_t;

endpackage

// [testbench/twst_slave_tx_props.sv]
// Property checker for the two-wire slave transmitter
`timescale 1ns/1ps
module twst_slave_tx_props (
  input wire logic                 ref_clk,
  input wire logic                 srst,
  input wire twst_pkg::twst_sw_t   sw,
  input wire logic [6:0]           own_addr,
  input wire logic                 arb_lost,
  input wire logic                 scl_i,
  input wire logic                 sda_i,
  input wire logic                 scl_o,
  input wire logic                 scl_oe,
  input wire logic                 sda_o,
  input wire logic                 sda_oe,
  input wire twst_pkg::twst_stat_t stat
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  wire logic [7:0] st = stat.status_register;
  wire logic       fl = stat.interrupt_flag;
  a_idle_code: assert property (!fl |-> st == twst_pkg::ST_NO_INFO)
    else $error("status not idle code with flag clear");
  a_low_bits: assert property (st[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_clear_idle: assert property (sw.flag_clear && fl |=> !fl && st == 8'hF8)
    else $error("flag clear not taken");
  a_codes_legal: assert property (fl |-> st inside {8'hA8, 8'hB0, 8'hB8, 8'hC0,
    8'hC8, 8'h00}) else $error("unexpected status code");
  a_stretch_on: assert property ($rose(fl) && st != 8'h00 |-> ##[1:4] scl_oe)
    else $error("clock not held after event");
  a_stretch_end: assert property ($fell(scl_oe) |-> $past(sw.flag_clear)
    || $past(sw.flag_clear, 2)) else $error("clock released without flag clear");
  a_err_free: assert property (fl && st == 8'h00 |=> !scl_oe && !sda_oe)
    else $error("lines driven in bus error");
  a_stop_drop: assert property (sw.flag_clear && fl && st == 8'h00
    && stat.stop_request_bit |=> !stat.stop_request_bit && !fl)
    else $error("bus error recovery failed");
  a_stop_take: assert property (sw.stop_set && !sw.flag_clear |=> stat.stop_request_bit)
    else $error("stop bit not set");
  a_start_once: assert property (stat.start_issue |=> !stat.start_issue)
    else $error("start request longer than a cycle");
  a_drive_value_low: assert property (!scl_o && !sda_o)
    else $error("open-drain data value not low");
  cover property ($rose(fl) && st == twst_pkg::ST_ARB_READ);
  cover property ($rose(fl) && st == twst_pkg::ST_OWN_READ);
  cover property ($rose(fl) && st == twst_pkg::ST_LAST_ACK);
  cover property ($rose(fl) && st == twst_pkg::ST_BUS_ERR);
endmodule

bind twst_slave_tx twst_slave_tx_props u_props (.ref_clk, .srst, .sw, .own_addr, .arb_lost,
  .scl_i, .sda_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .stat);

// [testbench/twst_master_model.sv]
// Bus master receiver model on open-drain lines
`timescale 1ns/1ps
module twst_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_m,
  output logic      sda_m
);
  int stuck = 0;
  initial begin
    scl_m = 1;
    sda_m = 1;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #40 scl_m = 1;
    for (int i = 0; i < 4000 && scl !== 1'b1; i++) #5;
    if (scl !== 1'b1) stuck++;
    #40 r = sda;
    #40 scl_m = 0;
    #40;
  endtask
  task automatic start();
    sda_m = 1;
    #40 scl_m = 1;
    #40 sda_m = 0;
    #40 scl_m = 0;
    #40;
  endtask
  task automatic stop();
    sda_m = 0;
    #40 scl_m = 1;
    #40 sda_m = 1;
    #80;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(ack, r);
  endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
module tb;
  logic [6:0]           own_addr = 7'h01;
  logic                 ref_clk = 0;
  logic                 srst = 1;
  logic                 arb_lost = 0;
  logic                 start_req = 0;
  twst_pkg::twst_sw_t   sw = '0;
  twst_pkg::twst_stat_t stat;
  logic                 scl_oe, sda_oe, scl_m, sda_m, fl, ack;
  logic [7:0]           s, d;
  logic [7:0]           exp_q[$];
  logic [8:0]           tx_q[$], ref_q[$];
  int                   num_errors = 0;
  int                   total_checks = 0;
  int                   n_start = 0;
  wire logic            scl = scl_m & ~scl_oe;
  wire logic            sda = sda_m & ~sda_oe;
  twst_slave_tx u_twst_slave_tx (.ref_clk, .srst, .sw, .own_addr, .arb_lost,
    .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe, .sda_o(), .sda_oe, .stat);
  twst_master_model u_m (.scl, .sda, .scl_m, .sda_m);
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (stat.start_issue === 1'b1) n_start++;
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    num_errors += u_m.stuck;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Software side: compares each status, then answers it
  initial begin
    fl = 0;
    forever begin
      tick();
      if (stat.interrupt_flag === 1'b1 && !fl) begin
        s = stat.status_register;
        chk(s, exp_q.size() > 0 ? exp_q.pop_front() : 8'h01);
        if (s[7:4] == 4'hA || s[7:4] == 4'hB) begin
          {sw.ack_enable, sw.data} = tx_q.pop_front();
          sw.data_load = 1;
        end
        else if (s == twst_pkg::ST_BUS_ERR) sw.stop_set = 1;
        else begin
          sw.ack_enable = 1;
          sw.start_request = start_req;
        end
        tick();
        sw.data_load = 0;
        sw.stop_set = 0;
        sw.flag_clear = 1;
        tick();
        sw.flag_clear = 0;
      end
      fl = stat.interrupt_flag;
    end
  end
  task automatic rd_seq(input bit pre_w, input bit arb, input int nb, input bit lack);
    for (int i = 0; i < nb; i++) tx_q.push_back({1'(i < nb - 1), 8'($urandom)});
    ref_q = tx_q;
    exp_q.push_back(arb ? twst_pkg::ST_ARB_READ : twst_pkg::ST_OWN_READ);
    for (int i = 1; i < nb; i++) exp_q.push_back(twst_pkg::ST_DATA_ACK);
    exp_q.push_back(lack ? twst_pkg::ST_DATA_NACK : twst_pkg::ST_LAST_ACK);
    tick();
    arb_lost = arb;
    tick();
    arb_lost = 0;
    u_m.start();
    if (pre_w) begin
      u_m.wr_byte({own_addr, 1'b0}, ack);
      chk(8'(ack), 8'h00);
      chk(8'(stat.slave_rx), 8'h01);
      u_m.start();
    end
    u_m.wr_byte({own_addr, 1'b1}, ack);
    chk(8'(ack), 8'h00);
    for (int i = 0; i < nb; i++) begin
      u_m.rd_byte(i == nb - 1 ? lack : 1'b0, d);
      chk(d, ref_q[i][7:0]);
    end
    if (!lack) u_m.rd_byte(1'b1, d);
    if (!lack) chk(d, 8'hFF);
    u_m.stop();
  endtask
  initial begin
    void'($urandom(32'h1CA76CE1));
    own_addr = 7'($urandom_range(1, 127));
    sw.ack_enable = 1;
    repeat (4) @(posedge ref_clk);
    #1;
    srst = 0;
    repeat (4) tick();
    start_req = 1;
    rd_seq(0, 0, 3, 1);
    start_req = 0;
    repeat (20) tick();
    chk(8'(n_start), 8'h01);
    $display("Test 1 done");
    rd_seq(0, 1, 2, 0);
    $display("Test 2 done");
    rd_seq(1, 0, 1, 1);
    $display("Test 3 done");
    for (int i = 0; i < 5; i++) begin
      tick();
      sw.ack_enable = i[1];
      sw.general_call_enable = i[0];
      u_m.start();
      u_m.wr_byte(i == 4 ? {own_addr, 1'b1} : 8'h00, ack);
      chk(8'(ack), 8'(i != 3));
      u_m.stop();
    end
    tick();
    sw.ack_enable = 1;
    sw.general_call_enable = 0;
    $display("Test 4 done");
    exp_q.push_back(twst_pkg::ST_BUS_ERR);
    u_m.start();
    for (int i = 0; i < 3; i++) u_m.bit_io(1'b1, ack);
    u_m.start();
    repeat (100) tick();
    chk(8'(stat.stop_request_bit), 8'h00);
    chk(stat.status_register, twst_pkg::ST_NO_INFO);
    u_m.stop();
    rd_seq(0, 0, 1, 1);
    $display("Test 5 done");
    chk(8'(exp_q.size()), 8'h00);
    chk(8'(n_start), 8'h01);
    close_out();
  end
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
